// File: logic/asb_host.sv
// Host controller for a 16-bit asynchronous static memory with lane selects.
// Assumes requests are synchronous to clk_sys_i; the bench resolves the
// shared data bus from the two output enables.
`timescale 1ns/10ps
`default_nettype none
// Function
// RULE_01: Write starts when strobe, selects, lane all active
// RULE_02: Write ends when any qualifier goes inactive
// RULE_03: Host holds data around write-ending edge
// RULE_04: Output gate high keeps memory pins undriven
// RULE_05: Joint deselect with strobe high stays undriven
// RULE_06: Host never drives while memory drives
// RULE_07: Write strobe stays high during reads
// RULE_08: Address valid before selects go active
// RULE_09: Read data follows address while selected
// RULE_10: Both lanes low reads full word
// RULE_11: Lower lane only reads low byte
// RULE_12: Upper lane only reads high byte
// RULE_13: Both lanes low writes full word
// RULE_14: Lower lane only writes low byte
// RULE_15: Upper lane only writes high byte
// RULE_16: Output gate high means no drive
// RULE_17: Chip select inactive means deselect, standby
// RULE_18: Both lanes high also deselects
// RULE_19: One word per access, data retained
// RULE_20: Host drivers off except during writes
module asb_host
  import asb_pkg::*;
(
  input  wire logic                  clk_sys_i,
  input  wire logic                  rst_i,
  input  wire logic                  ce_i,
  // User request side
  input  wire logic                  req_valid_i,
  input  wire logic                  req_write_i,
  input  wire logic [ASB_ADDR_W-1:0] req_addr_i,
  input  wire logic [ASB_BE_W-1:0]   req_be_i,
  input  wire logic [ASB_DATA_W-1:0] req_wdata_i,
  output logic                       req_ready_o,
  output logic                       rsp_valid_o,
  output logic [ASB_DATA_W-1:0]      rsp_rdata_o,
  // Memory pins
  output logic [ASB_ADDR_W-1:0]      mem_addr_o,
  output logic                       mem_sel_n_o,
  output logic                       mem_sel_o,
  output logic                       mem_write_n_o,
  output logic                       mem_out_gate_n_o,
  output logic                       upper_lane_select_n_o,
  output logic                       lower_lane_select_n_o,
  input  wire logic [ASB_DATA_W-1:0] mem_data_i,
  output logic [ASB_DATA_W-1:0]      mem_data_o,
  output logic                       mem_data_oe_o
);

  // ----------------------------------------------------------------
  // Lane helpers
  // ----------------------------------------------------------------
  // Lane selects are active low; an empty byte mask would deselect.
  function automatic logic [1:0] lane_n(input logic [1:0] be);
    lane_n = ~be;
  endfunction

  // Keep only the enabled byte lanes of a captured word.
  function automatic logic [15:0] lane_mask(input logic [1:0] be,
                                            input logic [15:0] d);
    lane_mask = {be[ASB_HI_LANE] ? d[15:8] : 8'h00,
                 be[ASB_LO_LANE] ? d[7:0]  : 8'h00};
  endfunction

  asb_tmr_if tmr ();

  asb_timer u_timer
  (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .ce_i      (ce_i),
    .tmr       (tmr.tmr)
  );

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  asb_state_type             state;
  asb_state_type             next_state;
  logic                      wr;
  logic                      next_wr;
  logic [ASB_BE_W-1:0]       be;
  logic [ASB_BE_W-1:0]       next_be;
  logic [ASB_ADDR_W-1:0]     next_addr;
  logic                      next_sel_n;
  logic                      next_sel;
  logic                      next_write_n;
  logic                      next_gate_n;
  logic [1:0]                next_lanes_n;
  logic [1:0]                lanes_n;
  logic [ASB_DATA_W-1:0]     next_wdata;
  logic                      next_oe;
  logic                      next_ready;
  logic                      next_rsp_valid;
  logic [ASB_DATA_W-1:0]     next_rdata;

  always_comb
  begin
    next_state     = state;
    next_wr        = wr;
    next_be        = be;
    next_addr      = mem_addr_o;
    next_sel_n     = mem_sel_n_o;
    next_sel       = mem_sel_o;
    next_write_n   = mem_write_n_o;
    next_gate_n    = mem_out_gate_n_o;
    next_lanes_n   = lanes_n;
    next_wdata     = mem_data_o;
    next_oe        = mem_data_oe_o;
    next_ready     = req_ready_o;
    next_rsp_valid = 1'b0;
    next_rdata     = rsp_rdata_o;
    tmr.load       = 1'b0;
    tmr.count      = '0;
    unique case (state)
      ASB_IDLE:
      begin
        // Empty byte mask would be a deselect, so it is refused
        if (req_valid_i && req_ready_o && (req_be_i != '0))
        begin
          // Address first, selects one cycle later
          next_addr  = req_addr_i; // RULE_08 RULE_19
          next_wr    = req_write_i;
          next_be    = req_be_i;
          next_wdata = req_wdata_i;
          next_ready = 1'b0;
          next_state = ASB_SETUP;
        end
      end
      ASB_SETUP:
      begin
        next_sel_n   = 1'b0;
        next_sel     = 1'b1;
        next_lanes_n = lane_n(be); // RULE_10 RULE_11 RULE_12 RULE_18
        if (wr)
        begin
          // Gate kept high so the memory cannot drive before the strobe
          next_gate_n  = 1'b1; // RULE_04 RULE_06
          next_write_n = 1'b0; // RULE_01 RULE_13 RULE_14 RULE_15
          next_oe      = 1'b1; // RULE_20
        end
        else
        begin
          next_gate_n  = 1'b0;
          next_write_n = 1'b1; // RULE_07
          next_oe      = 1'b0; // RULE_06 RULE_20
        end
        tmr.load  = 1'b1;
        tmr.count = ASB_CNT_W'(ASB_ACCESS_CYC);
        next_state = ASB_ACCESS;
      end
      ASB_ACCESS:
      begin
        if (tmr.expired)
        begin
          if (wr)
          begin
            // Strobe ends the write; data held past that edge
            next_write_n = 1'b1; // RULE_02 RULE_03
            tmr.load     = 1'b1;
            tmr.count    = ASB_CNT_W'(ASB_HOLD_CYC);
            next_state   = ASB_HOLD;
          end
          else
          begin
            // Sample late so output has settled on the new address
            next_rdata = lane_mask(be, mem_data_i); // RULE_09 RULE_11 RULE_12
            next_rsp_valid = 1'b1;
            next_gate_n    = 1'b1; // RULE_16
            next_state     = ASB_HOLD;
          end
        end
      end
      ASB_HOLD:
      begin
        if (wr ? tmr.expired : 1'b1)
        begin
          // Selects released together, strobe already high
          next_sel_n   = 1'b1; // RULE_05 RULE_17
          next_sel     = 1'b0;
          next_lanes_n = ASB_LANES_OFF;
          next_oe      = 1'b0; // RULE_03 RULE_20
          next_state   = ASB_DONE;
        end
      end
      ASB_DONE:
      begin
        // One idle cycle so bus turnaround never overlaps
        next_ready = 1'b1; // RULE_06
        next_state = ASB_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      state            <= ASB_IDLE;
      wr               <= 1'b0;
      be               <= '0;
      mem_addr_o       <= ASB_ADDR_RST;
      mem_sel_n_o      <= 1'b1;
      mem_sel_o        <= 1'b0;
      mem_write_n_o    <= 1'b1;
      mem_out_gate_n_o <= 1'b1;
      lanes_n          <= ASB_LANES_OFF;
      mem_data_o       <= ASB_DATA_RST;
      mem_data_oe_o    <= 1'b0;
      req_ready_o      <= 1'b1;
      rsp_valid_o      <= 1'b0;
      rsp_rdata_o      <= ASB_DATA_RST;
    end
    else if (ce_i)
    begin
      state            <= next_state;
      wr               <= next_wr;
      be               <= next_be;
      mem_addr_o       <= next_addr;
      mem_sel_n_o      <= next_sel_n;
      mem_sel_o        <= next_sel;
      mem_write_n_o    <= next_write_n;
      mem_out_gate_n_o <= next_gate_n;
      lanes_n          <= next_lanes_n;
      mem_data_o       <= next_wdata;
      mem_data_oe_o    <= next_oe;
      req_ready_o      <= next_ready;
      rsp_valid_o      <= next_rsp_valid;
      rsp_rdata_o      <= next_rdata;
    end
  end

  // Lane pins are separate flops for the direct-from-register output
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      upper_lane_select_n_o <= 1'b1;
      lower_lane_select_n_o <= 1'b1;
    end
    else if (ce_i)
    begin
      upper_lane_select_n_o <= next_lanes_n[ASB_HI_LANE];
      lower_lane_select_n_o <= next_lanes_n[ASB_LO_LANE];
    end
  end

endmodule : asb_host
`default_nettype wire

// File: logic/asb_timer.sv
// Phase timer: loads a cycle count and flags when it has run out.
// Assumes clock enable and reset shared with the sequencer.
`timescale 1ns/10ps
`default_nettype none
module asb_timer
  import asb_pkg::*;
(
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  asb_tmr_if.tmr    tmr
);

  logic [ASB_CNT_W-1:0] cnt;
  logic [ASB_CNT_W-1:0] next_cnt;

  always_comb
  begin
    next_cnt = cnt;
    if (tmr.load)
      next_cnt = tmr.count;
    else if (cnt != '0)
      next_cnt = cnt - 1'b1;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      cnt <= '0;
    else if (ce_i)
      cnt <= next_cnt;
  end

  // Independent of load: the sequencer reloads on expiry, so gating with
  // load would close a zero-delay loop through the sequencer's decode
  assign tmr.expired = (cnt == '0);

endmodule : asb_timer
`default_nettype wire

// File: shared/asb_pkg.sv
// Package for the host-side controller of a 16-bit asynchronous static memory.
// Assumes one 20 MHz system clock; memory pins are driven from flip-flops.
package asb_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ASB_ADDR_W = 20;
  localparam int ASB_DATA_W = 16;
  localparam int ASB_BYTE_W = 8;
  localparam int ASB_BE_W   = 2;
  localparam int ASB_LO_LANE = 0;
  localparam int ASB_HI_LANE = 1;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int ASB_CLK_PERIOD_NS = 50;
  // Access phase and write-data hold, in ns
  localparam int ASB_ACCESS_NS     = 100;
  localparam int ASB_HOLD_NS       = 50;
  localparam int ASB_ACCESS_CYC =
    (ASB_ACCESS_NS + ASB_CLK_PERIOD_NS - 1) / ASB_CLK_PERIOD_NS;
  localparam int ASB_HOLD_CYC =
    (ASB_HOLD_NS + ASB_CLK_PERIOD_NS - 1) / ASB_CLK_PERIOD_NS;
  localparam int ASB_CNT_W = 4;

  // ----------------------------------------------------------------
  // Reset values of the memory pins (all deselected)
  // ----------------------------------------------------------------
  localparam logic [1:0] ASB_LANES_OFF = 2'h3;
  localparam logic [15:0] ASB_DATA_RST = 16'h0000;
  localparam logic [19:0] ASB_ADDR_RST = 20'h0_0000;

  typedef enum logic [2:0] {
    ASB_IDLE,
    ASB_SETUP,
    ASB_ACCESS,
    ASB_HOLD,
    ASB_DONE
  } asb_state_type;

endpackage : asb_pkg

// File: shared/asb_tmr_if.sv
// Interface between the sequencer and its phase timer.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
`default_nettype none
interface asb_tmr_if;
  import asb_pkg::*;
  logic                 load;
  logic [ASB_CNT_W-1:0] count;
  logic                 expired;
  modport seq (output load, output count, input expired);
  modport tmr (input load, input count, output expired);
endinterface : asb_tmr_if
`default_nettype wire

// File: test/asb_host_monitor.sv
// Checker for the host pins of the static memory controller.
// Assumes bind to asb_host; a request counts only on an enabled edge.
`timescale 1ns/10ps
`default_nettype none
module asb_host_monitor
  import asb_pkg::*;
(
  input wire logic                  clk_sys_i,
  input wire logic                  rst_i,
  input wire logic                  ce_i,
  input wire logic                  req_valid_i,
  input wire logic                  req_write_i,
  input wire logic [ASB_BE_W-1:0]   req_be_i,
  input wire logic                  req_ready_o,
  input wire logic                  rsp_valid_o,
  input wire logic [ASB_ADDR_W-1:0] mem_addr_o,
  input wire logic                  mem_sel_n_o,
  input wire logic                  mem_sel_o,
  input wire logic                  mem_write_n_o,
  input wire logic                  mem_out_gate_n_o,
  input wire logic                  upper_lane_select_n_o,
  input wire logic                  lower_lane_select_n_o,
  input wire logic [ASB_DATA_W-1:0] mem_data_o,
  input wire logic                  mem_data_oe_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  logic take;
  assign take = ce_i && req_valid_i && req_ready_o && (req_be_i != 2'h0);
  // ------------------------------------------------------------
  // Pin relations
  // ------------------------------------------------------------
  AST_SEL_PAIR: assert property (mem_sel_n_o == !mem_sel_o)
    else $error("chip selects disagree");
  AST_STROBE_IN_READ: assert property (!mem_out_gate_n_o |->
    mem_write_n_o)
    else $error("write strobe low while gate open");
  AST_NO_FIGHT: assert property (mem_data_oe_o |-> mem_out_gate_n_o)
    else $error("host drives with gate open");
  AST_DRIVE_IN_WRITE: assert property (mem_data_oe_o |-> !mem_sel_n_o)
    else $error("host drives while deselected");
  AST_ADDR_HELD: assert property (!mem_sel_n_o |-> $stable(mem_addr_o))
    else $error("address moved while selected");
  AST_DATA_HOLD: assert property ($rose(mem_write_n_o) |->
    mem_data_oe_o && !mem_sel_n_o && $stable(mem_data_o))
    else $error("write data not held at strobe end");
  AST_NO_EMPTY_SELECT: assert property (!mem_sel_n_o |->
    !(upper_lane_select_n_o && lower_lane_select_n_o))
    else $error("selected with no lane");
  AST_READ_ANSWER: assert property (take && !req_write_i |->
    ##[4:6] rsp_valid_o)
    else $error("read answer missing");
  AST_WRITE_STROBE: assert property (take && req_write_i |->
    ##[1:3] !mem_write_n_o)
    else $error("write strobe missing");
endmodule : asb_host_monitor
bind asb_host asb_host_monitor asb_host_monitor_i (.clk_sys_i, .rst_i, .ce_i,
  .req_valid_i, .req_write_i, .req_be_i, .req_ready_o, .rsp_valid_o,
  .mem_addr_o, .mem_sel_n_o, .mem_sel_o, .mem_write_n_o, .mem_out_gate_n_o,
  .upper_lane_select_n_o, .lower_lane_select_n_o, .mem_data_o,
  .mem_data_oe_o);
`default_nettype wire

// File: test/asb_mem_model.sv
// Behavioural 16-bit static memory with lane selects, no clock.
// Assumes the bench resolves the shared data bus per byte lane.
`timescale 1ns/10ps
`default_nettype none
module asb_mem_model
  import asb_pkg::*;
(
  input wire logic [ASB_ADDR_W-1:0] addr_i,
  input wire logic                  sel_n_i,
  input wire logic                  sel_i,
  input wire logic                  write_n_i,
  input wire logic                  gate_n_i,
  input wire logic                  upper_n_i,
  input wire logic                  lower_n_i,
  input wire logic [ASB_DATA_W-1:0] dq_i,
  output logic [ASB_DATA_W-1:0]     dq_o,
  output logic [1:0]                dq_oe_o
);
  // Only 256 words kept: upper address bits fold onto them
  logic [15:0] mem [0:255] = '{default: 16'h0000};
  logic        on;
  logic        wr;
  // ------------------------------------------------------------
  // Mode decode
  // ------------------------------------------------------------
  assign on = !sel_n_i && sel_i && !(upper_n_i && lower_n_i);
  assign wr = on && !write_n_i;
  always @*
    if (wr)
    begin
      if (!lower_n_i) mem[addr_i[7:0]][7:0] = dq_i[7:0];
      if (!upper_n_i) mem[addr_i[7:0]][15:8] = dq_i[15:8];
    end
  assign dq_o = mem[addr_i[7:0]];
  assign dq_oe_o = {2{on && write_n_i && !gate_n_i}}
                 & ~{upper_n_i, lower_n_i};
endmodule : asb_mem_model
`default_nettype wire

// File: test/tb.sv
// Self-checking bench: host controller against the memory model.
// Assumes a 20 MHz clock; undriven bus lanes toggle every cycle.
`timescale 1ns/10ps
`default_nettype none
module tb;
  import asb_pkg::*;
  logic clk_sys_i, rst_i, req_valid_i, req_write_i, req_ready_o, rsp_valid_o;
  logic mem_sel_n_o, mem_sel_o, mem_write_n_o, mem_out_gate_n_o, tog = 1'b0;
  logic ce_i;
  logic upper_lane_select_n_o, lower_lane_select_n_o, mem_data_oe_o;
  logic [ASB_ADDR_W-1:0] req_addr_i, mem_addr_o;
  logic [1:0]            req_be_i, dq_oe;
  logic [15:0]           req_wdata_i, rsp_rdata_o, mem_data_o;
  logic [15:0]           mem_data_i, dq, q;
  int                    err_count, tests_run;
  asb_host asb_host_i (.clk_sys_i, .rst_i, .ce_i, .req_valid_i,
    .req_write_i, .req_addr_i, .req_be_i, .req_wdata_i, .req_ready_o,
    .rsp_valid_o, .rsp_rdata_o, .mem_addr_o, .mem_sel_n_o, .mem_sel_o,
    .mem_write_n_o, .mem_out_gate_n_o, .upper_lane_select_n_o,
    .lower_lane_select_n_o, .mem_data_i, .mem_data_o, .mem_data_oe_o);
  asb_mem_model asb_mem_model_i (.addr_i(mem_addr_o), .sel_n_i(mem_sel_n_o),
    .sel_i(mem_sel_o), .write_n_i(mem_write_n_o), .gate_n_i(mem_out_gate_n_o),
    .upper_n_i(upper_lane_select_n_o), .lower_n_i(lower_lane_select_n_o),
    .dq_i(mem_data_i), .dq_o(dq), .dq_oe_o(dq_oe));
  // ------------------------------------------------------------
  // Bus resolution and stimulus
  // ------------------------------------------------------------
  // One driver per byte lane; an undriven lane shows a moving pattern
  assign mem_data_i = mem_data_oe_o ? mem_data_o
    : {dq_oe[1] ? dq[15:8] : {8{tog}}, dq_oe[0] ? dq[7:0] : {8{tog}}};
  always @(posedge clk_sys_i) tog <= !tog;
  initial
  begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [19:0] a,
                      input logic [1:0] be, input logic [15:0] d,
                      output logic [15:0] r);
    int n;
    n = 0;
    r = 16'hxxxx;
    @(posedge clk_sys_i);
    req_valid_i <= 1'b1;
    req_write_i <= w;
    req_addr_i <= a;
    req_be_i <= be;
    req_wdata_i <= d;
    @(posedge clk_sys_i);
    req_valid_i <= 1'b0;
    do
    begin
      @(posedge clk_sys_i);
      #1;
      if (rsp_valid_o === 1'b1) r = rsp_rdata_o;
      n++;
    end while (req_ready_o !== 1'b1 && n < 20);
    chk({15'h0000, req_ready_o}, 16'h0001);
  endtask
  task automatic t_idle;
    logic [15:0] pins;
    @(posedge clk_sys_i);
    #1;
    pins = {10'h000, mem_sel_n_o, mem_sel_o, upper_lane_select_n_o,
            lower_lane_select_n_o, mem_data_oe_o, req_ready_o};
    chk(pins, 16'h002D);
  endtask
  // Clock enable low: a pending read must wait, then run at full length
  task automatic t_freeze;
    @(posedge clk_sys_i);
    ce_i <= 1'b0;
    req_valid_i <= 1'b1;
    req_write_i <= 1'b0;
    req_addr_i <= 20'h0_0021;
    req_be_i <= 2'h3;
    repeat (3) @(posedge clk_sys_i);
    #1;
    chk({14'h0000, req_ready_o, mem_sel_n_o}, 16'h0003);
    @(posedge clk_sys_i);
    ce_i <= 1'b1;
    @(posedge clk_sys_i);
    req_valid_i <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    #1;
    chk({15'h0000, rsp_valid_o}, 16'h0001);
    chk(rsp_rdata_o, 16'h1111);
    repeat (2) @(posedge clk_sys_i);
    #1;
    chk({15'h0000, req_ready_o}, 16'h0001);
  endtask
  task automatic t_lanes;
    xfer(1'b1, 20'h0_0021, 2'h3, 16'h1111, q);
    xfer(1'b1, 20'h0_0020, 2'h3, 16'hAAAA, q);
    xfer(1'b0, 20'h0_0020, 2'h3, 16'h0000, q);
    chk(q, 16'hAAAA);
    xfer(1'b1, 20'h0_0020, 2'h1, 16'h1234, q);
    xfer(1'b0, 20'h0_0020, 2'h3, 16'h0000, q);
    chk(q, 16'hAA34);
    xfer(1'b1, 20'h0_0020, 2'h2, 16'h5678, q);
    xfer(1'b0, 20'h0_0020, 2'h3, 16'h0000, q);
    chk(q, 16'h5634);
    xfer(1'b0, 20'h0_0020, 2'h1, 16'h0000, q);
    chk(q, 16'h0034);
    xfer(1'b0, 20'h0_0020, 2'h2, 16'h0000, q);
    chk(q, 16'h5600);
    xfer(1'b0, 20'h0_0021, 2'h3, 16'h0000, q);
    chk(q, 16'h1111);
  endtask
  task automatic t_refuse;
    @(posedge clk_sys_i);
    req_valid_i <= 1'b1;
    req_write_i <= 1'b1;
    req_be_i <= 2'h0;
    repeat (4) @(posedge clk_sys_i);
    #1;
    chk({14'h0000, req_ready_o, mem_sel_n_o}, 16'h0003);
    @(posedge clk_sys_i);
    req_valid_i <= 1'b0;
  endtask
  task automatic close_out;
    if (err_count == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    rst_i = 1'b1;
    ce_i = 1'b1;
    req_valid_i = 1'b0;
    req_write_i = 1'b0;
    req_addr_i = 20'h0_0000;
    req_be_i = 2'h0;
    req_wdata_i = 16'h0000;
    err_count = 0;
    tests_run = 0;
    repeat (16) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    t_idle;
    t_lanes;
    t_freeze;
    t_refuse;
    close_out;
  end
  // Whole run is about 120 cycles; the limit leaves a wide margin
  initial
  begin
    repeat (2000) @(posedge clk_sys_i);
    err_count++;
    close_out;
  end
endmodule : tb
`default_nettype wire
